// [rtl/rpi_pkg.sv]
// Purpose: Shared constants and types of the reset and pull-up init block.
// Assumes: 8-bit registers on a plain strobe port, 10-bit byte addresses.
// Notes:   Offsets, reset values and cycle counts live here only.

package rpi_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 8;

    localparam logic [9:0] OFS_PROC_MODE   = 10'h004;
    localparam logic [9:0] OFS_RESET_STAT  = 10'h3F0;
    localparam logic [9:0] OFS_PULLUP_ONE  = 10'h3FD;
    localparam logic [9:0] OFS_PULLUP_TWO  = 10'h3FE;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned STAT_RAM_UNDEF_BIT = 0;
    localparam int unsigned STAT_LAST_SW_BIT   = 1;

    localparam logic [7:0] PULLUP_RST_LOW  = 8'h00;
    localparam logic [7:0] PULLUP_RST_HIGH = 8'h02;
    localparam logic [1:0] MODE_SINGLE     = 2'h0;
    localparam logic [1:0] MODE_MICROPROC  = 2'h3;
    localparam logic [7:0] READ_ZERO       = 8'h00;

    // ------------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------------
    localparam int unsigned CNT_W           = 5;
    localparam logic [4:0]  HOLD_CYCLES     = 5'h14;
    localparam logic [4:0]  SW_RESET_CYCLES = 5'h04;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    // Processor mode control register layout
    typedef struct packed {
        logic [3:0] rsv_hi;
        logic       sw_reset;
        logic       rsv_lo;
        logic [1:0] mode;
    } rpi_pm_t;

    // Reset fan-out toward pins, oscillator and core
    typedef struct packed {
        logic pin_force;
        logic osc_reset;
        logic core_reset;
        logic vector_fetch;
    } rpi_rst_out_t;

    // Sequencer states
    typedef enum logic [4:0] {
        ST_HW_HOLD = 5'b00001,
        ST_INIT    = 5'b00010,
        ST_FETCH   = 5'b00100,
        ST_RUN     = 5'b01000,
        ST_SW      = 5'b10000
    } rpi_state_t;

endpackage : rpi_pkg

// [rtl/rpi_reset_ctrl.sv]
// Purpose: Reset sequencer with pull-up control register initialisation.
// Assumes: clk_sys is the main clock and keeps running during reset.
// Notes:   Reset pin and mode strap are asynchronous and are synchronised.
//
// The implementer's own choice: the address-and-strobe port.

`timescale 1ns/1ps

module rpi_reset_ctrl (
    input  wire logic                clk_sys,
    input  wire logic                rstn,
    input  wire logic                reset_pin_n,
    input  wire logic                mode_strap_pin,
    input  wire logic                ram_write_busy,
    input  wire logic [9:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [7:0]          reg_rdata,
    output rpi_pkg::rpi_rst_out_t    rst_out,
    output logic                     ram_write_block,
    output logic      [7:0]          pullup_control_one,
    output logic      [7:0]          pullup_control_two,
    output logic      [1:0]          proc_mode
);

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    logic [1:0] pins_sync;
    logic       pin_high;
    logic       strap_sync;

    // Reset pin reads as asserted until proven released
    rpi_sync #(
        .WIDTH   (2),
        .RST_VAL (2'h0)
    ) u_sync (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .async_in ({mode_strap_pin, reset_pin_n}),
        .sync_out (pins_sync)
    );

    assign pin_high   = pins_sync[0];
    assign strap_sync = pins_sync[1];

    // ------------------------------------------------------------------
    // State and storage
    // ------------------------------------------------------------------
    rpi_pkg::rpi_state_t   state_q;
    rpi_pkg::rpi_state_t   state_d;
    logic [4:0]            cnt_q;
    logic [4:0]            cnt_d;
    logic                  strap_q;
    logic                  last_sw_q;
    logic                  ram_undef_q;
    logic                  pin_high_q;
    logic [1:0]            mode_q;
    logic [7:0]            pur_one_q;
    logic [7:0]            pur_two_q;
    logic [7:0]            rdata_q;
    rpi_pkg::rpi_rst_out_t rst_out_q;
    rpi_pkg::rpi_rst_out_t rst_out_d;

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    rpi_pkg::rpi_pm_t pm_wr;
    logic             in_run;
    logic             hit_pm;
    logic             hit_stat;
    logic             hit_one;
    logic             hit_two;
    logic             wr_pm;
    logic             wr_stat;
    logic             wr_one;
    logic             wr_two;
    logic             sw_req;
    logic             stat_clr_ram;

    // Software can only reach registers while the core is running
    assign in_run   = (state_q == rpi_pkg::ST_RUN);
    assign hit_pm   = (reg_addr == rpi_pkg::OFS_PROC_MODE);
    assign hit_stat = (reg_addr == rpi_pkg::OFS_RESET_STAT);
    assign hit_one  = (reg_addr == rpi_pkg::OFS_PULLUP_ONE);
    assign hit_two  = (reg_addr == rpi_pkg::OFS_PULLUP_TWO);
    assign wr_pm    = reg_wr && in_run && hit_pm;
    assign wr_stat  = reg_wr && in_run && hit_stat;
    assign wr_one   = reg_wr && in_run && hit_one;
    assign wr_two   = reg_wr && in_run && hit_two;
    assign pm_wr    = rpi_pkg::rpi_pm_t'(reg_wdata);

    // Software reset request and write-one-to-clear of the RAM flag
    assign sw_req       = wr_pm && pm_wr.sw_reset;
    assign stat_clr_ram = wr_stat && reg_wdata[rpi_pkg::STAT_RAM_UNDEF_BIT];

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    logic hold_done;
    logic sw_done;

    // Early release is ignored until the minimum hold has elapsed
    assign hold_done = pin_high && (cnt_q >= rpi_pkg::HOLD_CYCLES);
    assign sw_done   = (cnt_q >= rpi_pkg::SW_RESET_CYCLES);

    // Pin low overrides every state, including a software reset
    always_comb begin
        state_d = state_q;
        if (!pin_high) begin
            state_d = rpi_pkg::ST_HW_HOLD;
        end else begin
            case (state_q)
                rpi_pkg::ST_HW_HOLD: begin
                    if (hold_done) begin
                        state_d = rpi_pkg::ST_INIT;
                    end
                end
                rpi_pkg::ST_INIT: begin
                    state_d = rpi_pkg::ST_FETCH;
                end
                rpi_pkg::ST_FETCH: begin
                    state_d = rpi_pkg::ST_RUN;
                end
                rpi_pkg::ST_RUN: begin
                    if (sw_req) begin
                        state_d = rpi_pkg::ST_SW;
                    end
                end
                rpi_pkg::ST_SW: begin
                    if (sw_done) begin
                        state_d = rpi_pkg::ST_INIT;
                    end
                end
                default: begin
                    state_d = rpi_pkg::ST_HW_HOLD;
                end
            endcase
        end
    end

    // Counter restarts on every state change and saturates
    always_comb begin
        if (state_d != state_q) begin
            cnt_d = '0;
        end else if (cnt_q != 5'h1F) begin
            cnt_d = cnt_q + 5'h01;
        end else begin
            cnt_d = cnt_q;
        end
    end

    // Registered fan-out; the core leaves reset in one single cycle
    always_comb begin
        rst_out_d.pin_force    = (state_d == rpi_pkg::ST_HW_HOLD) ||
                                 (state_d == rpi_pkg::ST_SW);
        rst_out_d.osc_reset    = (state_d == rpi_pkg::ST_HW_HOLD);
        rst_out_d.core_reset   = (state_d == rpi_pkg::ST_HW_HOLD) ||
                                 (state_d == rpi_pkg::ST_SW) ||
                                 (state_d == rpi_pkg::ST_INIT);
        rst_out_d.vector_fetch = (state_d == rpi_pkg::ST_FETCH);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q   <= rpi_pkg::ST_HW_HOLD;
            cnt_q     <= '0;
            rst_out_q <= '{pin_force: 1'b1, osc_reset: 1'b1,
                           core_reset: 1'b1, vector_fetch: 1'b0};
        end else begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            rst_out_q <= rst_out_d;
        end
    end

    // ------------------------------------------------------------------
    // Strap capture and reset history
    // ------------------------------------------------------------------
    logic pin_fall;
    logic ram_undef_set;

    assign pin_fall      = pin_high_q && !pin_high;
    assign ram_undef_set = pin_fall && ram_write_busy;

    // Strap is tracked only while held in hardware reset
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            strap_q     <= 1'b0;
            last_sw_q   <= 1'b0;
            pin_high_q  <= 1'b0;
            ram_undef_q <= 1'b0;
        end else begin
            pin_high_q <= pin_high;
            if (state_q == rpi_pkg::ST_HW_HOLD) begin
                strap_q   <= strap_sync;
                last_sw_q <= 1'b0;
            end else if (state_q == rpi_pkg::ST_SW) begin
                last_sw_q <= 1'b1;
            end
            // A new event beats a clear in the same cycle
            if (ram_undef_set) begin
                ram_undef_q <= 1'b1;
            end else if (stat_clr_ram) begin
                ram_undef_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Mode field and pull-up control registers
    // ------------------------------------------------------------------
    logic [7:0] pur_hw_val;
    logic [7:0] pur_sw_val;
    logic [7:0] pur_init_val;
    logic       do_init;

    // Reserved mode 10b shares the expansion value; it must not be used
    assign pur_hw_val   = strap_q ? rpi_pkg::PULLUP_RST_HIGH
                                  : rpi_pkg::PULLUP_RST_LOW;
    assign pur_sw_val   = (mode_q == rpi_pkg::MODE_SINGLE)
                          ? rpi_pkg::PULLUP_RST_LOW
                          : rpi_pkg::PULLUP_RST_HIGH;
    assign pur_init_val = last_sw_q ? pur_sw_val : pur_hw_val;
    assign do_init      = (state_q == rpi_pkg::ST_INIT);

    // Mode survives a software reset; only the hardware path reloads it
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mode_q <= rpi_pkg::MODE_SINGLE;
        end else if (do_init && !last_sw_q) begin
            mode_q <= strap_q ? rpi_pkg::MODE_MICROPROC
                              : rpi_pkg::MODE_SINGLE;
        end else if (wr_pm) begin
            mode_q <= pm_wr.mode;
        end
    end

    // Async reset loads 00h and 02h; init loads both with the same value
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pur_one_q <= rpi_pkg::PULLUP_RST_LOW;
            pur_two_q <= rpi_pkg::PULLUP_RST_HIGH;
        end else if (do_init) begin
            pur_one_q <= pur_init_val;
            pur_two_q <= pur_init_val;
        end else begin
            if (wr_one) begin
                pur_one_q <= reg_wdata;
            end
            if (wr_two) begin
                pur_two_q <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    rpi_pkg::rpi_pm_t pm_rd;
    logic [7:0]       stat_rd;
    logic [7:0]       rdata_d;

    assign pm_rd   = '{rsv_hi: 4'h0, sw_reset: 1'b0, rsv_lo: 1'b0,
                       mode: mode_q};
    assign stat_rd = {6'h00, last_sw_q, ram_undef_q};

    // Unmapped addresses read zero and ignore writes
    assign rdata_d = !(reg_rd && in_run) ? rpi_pkg::READ_ZERO :
                     hit_pm   ? 8'(pm_rd) :
                     hit_stat ? stat_rd :
                     hit_one  ? pur_one_q :
                     hit_two  ? pur_two_q :
                     rpi_pkg::READ_ZERO;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= rpi_pkg::READ_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // RAM is only write-blocked, never cleared, so contents survive
    assign ram_write_block    = rst_out_q.pin_force;
    assign rst_out            = rst_out_q;
    assign reg_rdata          = rdata_q;
    assign pullup_control_one = pur_one_q;
    assign pullup_control_two = pur_two_q;
    assign proc_mode          = mode_q;

endmodule : rpi_reset_ctrl

// [rtl/rpi_sync.sv]
// Purpose: Two-flop synchroniser for a group of asynchronous levels.
// Assumes: Each bit is an independent level; no bus coherence needed.
// Notes:   The first stage feeds only the second stage.

`timescale 1ns/1ps

module rpi_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] meta_q;

    // Two stages keep metastability away from the sequencer
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta_q   <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : rpi_sync

// [test/rpi_reset_ctrl_properties.sv]
// Purpose: Port-level assertions for the reset controller.
// Assumes: One clock domain; rstn clears the helper state.
// Notes:   Pin history keeps checks clear of a fresh pin reset.
`timescale 1ns/1ps

module rpi_props (
    input wire logic            clk_sys,
    input wire logic            rstn,
    input wire logic            reset_pin_n,
    input wire logic [9:0]      reg_addr,
    input wire logic [7:0]      reg_wdata,
    input wire logic            reg_wr,
    input wire logic            reg_rd,
    input wire logic [7:0]      reg_rdata,
    input rpi_pkg::rpi_rst_out_t rst_out,
    input wire logic            ram_write_block,
    input wire logic [7:0]      pullup_control_one,
    input wire logic [7:0]      pullup_control_two,
    input wire logic [1:0]      proc_mode
);
    logic [3:0] pin_hist_q;
    logic [5:0] osc_cnt_q;
    wire        quiet;

    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    // Sync lag hides a fresh pin fall, so demand a quiet history
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pin_hist_q <= 4'h0;
            osc_cnt_q  <= 6'h00;
        end else begin
            pin_hist_q <= {pin_hist_q[2:0], reset_pin_n};
            if (!rst_out.osc_reset)
                osc_cnt_q <= 6'h00;
            else if (osc_cnt_q != 6'h3F)
                osc_cnt_q <= osc_cnt_q + 6'h01;
        end
    end
    assign quiet = (&pin_hist_q) & reset_pin_n & ~rst_out.core_reset
                 & ~rst_out.vector_fetch;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    chk_pin_forced: assert property (
        !reset_pin_n [*7] |-> rst_out.pin_force)
        else $error("pins not forced while reset pin low");
    chk_osc_start: assert property (
        $fell(reset_pin_n) |-> ##[1:6] rst_out.osc_reset)
        else $error("oscillator reset missing");
    chk_hold_len: assert property (
        $fell(rst_out.osc_reset) |-> osc_cnt_q >= rpi_pkg::HOLD_CYCLES)
        else $error("hardware reset released too early");
    chk_vec_single: assert property (
        rst_out.vector_fetch |=> !rst_out.vector_fetch)
        else $error("vector fetch longer than one cycle");
    chk_vec_cause: assert property (
        rst_out.vector_fetch |-> reset_pin_n && $past(rst_out.core_reset))
        else $error("vector fetch without core reset release");
    chk_ram_guard: assert property (
        ram_write_block == rst_out.pin_force)
        else $error("ram write block differs from pin force");
    chk_init_pullups: assert property (
        rst_out.vector_fetch |-> pullup_control_one == pullup_control_two
        && pullup_control_one == ((proc_mode == rpi_pkg::MODE_SINGLE)
        ? rpi_pkg::PULLUP_RST_LOW : rpi_pkg::PULLUP_RST_HIGH))
        else $error("pull-up init value wrong");
    chk_sw_entry: assert property (
        quiet && reg_wr && reg_addr == rpi_pkg::OFS_PROC_MODE && reg_wdata[3]
        |-> ##[1:3] (rst_out.pin_force && rst_out.core_reset
        && !rst_out.osc_reset))
        else $error("software reset not entered");
    chk_mode_kept: assert property (
        $rose(rst_out.core_reset) && !rst_out.osc_reset
        |=> $stable(proc_mode) [*4])
        else $error("mode field changed by software reset");
    chk_rd_pullup: assert property (
        quiet && !$past(reg_wr) && reg_rd
        && reg_addr == rpi_pkg::OFS_PULLUP_ONE
        |=> reg_rdata == $past(pullup_control_one))
        else $error("pull-up read data wrong");
    chk_rd_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero when idle");

    cov_fetch: cover property (rst_out.vector_fetch);
    cov_sw: cover property ($rose(rst_out.core_reset) && !rst_out.osc_reset);
    cov_read: cover property (quiet && reg_rd);
endmodule : rpi_props

bind rpi_reset_ctrl rpi_props i_rpi_props (
    .clk_sys(clk_sys), .rstn(rstn), .reset_pin_n(reset_pin_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rst_out(rst_out),
    .ram_write_block(ram_write_block),
    .pullup_control_one(pullup_control_one),
    .pullup_control_two(pullup_control_two), .proc_mode(proc_mode));

// [test/rpi_reset_source.sv]
// Purpose: Model of the external reset circuit on the reset pin.
// Assumes: Pin has a pull-up, so a released pin reads high.
// Notes:   Holds the pin low for exactly the commanded count.
`timescale 1ns/1ps

module rpi_reset_source (
    input  wire logic       clk_sys,
    input  wire logic       go,
    input  wire logic [7:0] low_cycles,
    output logic            reset_pin_n
);
    // Power-up holds the pin low for 30 cycles, past the minimum hold
    logic [7:0] cnt_q = 8'h1E;
    logic       pin_q = 1'b0;

    // ------------------------------------------------------------
    // Pulse generator
    // ------------------------------------------------------------
    // Counts under 20 are only commanded to test the delayed release
    always_ff @(posedge clk_sys) begin
        if (go) begin
            cnt_q <= low_cycles;
            pin_q <= 1'b0;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q == 8'h01)
                pin_q <= 1'b1;
        end
    end
    assign reset_pin_n = pin_q;
endmodule : rpi_reset_source

// [test/tb.sv]
// Purpose: Self-checking bench of the reset and pull-up init block.
// Assumes: Strobe register port, reset pin from the source model.
// Notes:   Table rows cover plain accesses; resets are hand-written.
`timescale 1ns/1ps

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    err_count++; $display("Error %s exp %h got %h", nm, e, g); end end

module tb;
    typedef struct packed {
        logic       wr;
        logic [9:0] addr;
        logic [7:0] data;
    } rpi_row_t;

    logic                   clk_sys = 1'b0;
    logic                   rstn = 1'b0;
    logic                   mode_strap_pin = 1'b0;
    logic                   ram_write_busy = 1'b0;
    logic [9:0]             reg_addr = 10'h000;
    logic [7:0]             reg_wdata = 8'h00;
    logic                   reg_wr = 1'b0;
    logic                   reg_rd = 1'b0;
    logic                   go = 1'b0;
    logic [7:0]             low_cycles = 8'h00;
    logic [7:0]             rd_v;
    logic [7:0]             exp_v;
    logic                   reset_pin_n;
    logic [7:0]             reg_rdata;
    rpi_pkg::rpi_rst_out_t  rst_out;
    logic                   ram_write_block;
    logic [7:0]             pullup_control_one;
    logic [7:0]             pullup_control_two;
    logic [1:0]             proc_mode;
    int                     err_count = 0;
    int                     n_checks = 0;
    int                     n;
    rpi_row_t               rows [10] = '{
        '{1'b1, 10'h3FD, 8'hA5}, '{1'b0, 10'h3FD, 8'hA5},
        '{1'b1, 10'h3FE, 8'h5A}, '{1'b0, 10'h3FE, 8'h5A},
        '{1'b1, 10'h200, 8'hFF}, '{1'b0, 10'h200, 8'h00},
        '{1'b0, 10'h3FF, 8'h00}, '{1'b1, 10'h004, 8'hF1},
        '{1'b0, 10'h004, 8'h01}, '{1'b0, 10'h3F0, 8'h00}};

    always #5 clk_sys = ~clk_sys;

    rpi_reset_source i_rpi_reset_source (.clk_sys(clk_sys), .go(go),
        .low_cycles(low_cycles), .reset_pin_n(reset_pin_n));

    rpi_reset_ctrl i_rpi_reset_ctrl (.clk_sys(clk_sys), .rstn(rstn),
        .reset_pin_n(reset_pin_n), .mode_strap_pin(mode_strap_pin),
        .ram_write_busy(ram_write_busy), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rst_out(rst_out),
        .ram_write_block(ram_write_block),
        .pullup_control_one(pullup_control_one),
        .pullup_control_two(pullup_control_two), .proc_mode(proc_mode));

    // ------------------------------------------------------------
    // Bus and sequencing tasks
    // ------------------------------------------------------------
    task automatic bus_write(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : bus_write

    // Read data stand only in the cycle after the strobe
    task automatic bus_read(input logic [9:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask : bus_read

    // Bounded wait for the fetch pulse, then let the core reach run
    task automatic wait_fetch(output int cyc);
        cyc = 0;
        while (cyc < 300 && rst_out.vector_fetch !== 1'b1) begin
            @(posedge clk_sys);
            #1 cyc++;
        end
        `CHK("fetch", 1'b1, rst_out.vector_fetch)
        repeat (2) @(posedge clk_sys);
    endtask : wait_fetch

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    // Watchdog: fires after 20000 cycles; the whole run needs well under that
    initial begin
        #200000;
        err_count++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        wait_fetch(n);
        `CHK("pullup one", 8'h00, pullup_control_one)
        `CHK("pullup two", 8'h00, pullup_control_two)
        $display("test power-up done");
        foreach (rows[i]) begin
            if (rows[i].wr)
                bus_write(rows[i].addr, rows[i].data);
            else begin
                bus_read(rows[i].addr, rd_v);
                `CHK("table read", rows[i].data, rd_v)
            end
        end
        $display("test register table done");
        for (int m = 0; m < 4; m++) begin
            bus_write(rpi_pkg::OFS_PROC_MODE, 8'h08 | 8'(m));
            wait_fetch(n);
            exp_v = (m == 0) ? 8'h00 : 8'h02;
            `CHK("sw pullup one", exp_v, pullup_control_one)
            `CHK("sw pullup two", exp_v, pullup_control_two)
            `CHK("sw mode", 2'(m), proc_mode)
            bus_read(rpi_pkg::OFS_PULLUP_TWO, rd_v);
            `CHK("sw pullup read", exp_v, rd_v)
        end
        bus_read(rpi_pkg::OFS_RESET_STAT, rd_v);
        `CHK("status after sw", 8'h02, rd_v)
        $display("test software reset done");
        // Short pulse with a RAM write in flight and strap high
        @(posedge clk_sys);
        mode_strap_pin <= 1'b1;
        ram_write_busy <= 1'b1;
        low_cycles     <= 8'h05;
        go             <= 1'b1;
        @(posedge clk_sys);
        go             <= 1'b0;
        repeat (6) @(posedge clk_sys);
        ram_write_busy <= 1'b0;
        #1 `CHK("pin force", 1'b1, rst_out.pin_force)
        wait_fetch(n);
        `CHK("hold delayed", 1'b1, n >= 14)
        `CHK("hw pullup", 8'h02, pullup_control_two)
        `CHK("hw mode", 2'h3, proc_mode)
        bus_read(rpi_pkg::OFS_RESET_STAT, rd_v);
        `CHK("ram undefined", 8'h01, rd_v)
        bus_write(rpi_pkg::OFS_RESET_STAT, 8'h01);
        bus_read(rpi_pkg::OFS_RESET_STAT, rd_v);
        `CHK("ram flag clear", 8'h00, rd_v)
        $display("test hardware reset done");
        tally_and_finish();
    end
endmodule : tb
